// *** logic/rtcal_top.sv ***
// alarm configuration, alarm window and BCD value registers on AHB-Lite
// assumes: one slave on the bus, hready fed back from hreadyout
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`include "rtcal_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcal_top #(
   parameter int HALF_SEC_CYC = `RTCAL_HALF_SEC_NS / `RTCAL_CLK_NS
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // alarm request
   output logic             alarm_event
);

   rtcal_pkg::rtcal_state_t s_q;
   rtcal_pkg::rtcal_state_t s_d;

   logic        acc;
   logic        mapped;
   logic [4:0]  a_off;
   logic        lane_hi;
   logic        lane_lo;
   logic        tick;
   logic        match;
   logic        leap;
   logic        feb29;
   logic        ev_now;
   logic [15:0] win_rd;
   logic [15:0] cfg_rd;
   logic [15:0] wd;

   // merge written byte lanes, keep only implemented bits
   function automatic logic [15:0] wr16(
      input logic [15:0] old,
      input logic [15:0] dat,
      input logic        hi,
      input logic        lo,
      input logic [15:0] bits
   );
      logic [15:0] v;
      v = {hi ? dat[15:8] : old[15:8], lo ? dat[7:0] : old[7:0]};
      return v & bits;
   endfunction : wr16

   // bus side decode
   assign acc       = hsel & htrans[1] & hready;
   assign mapped    = (haddr[31:5] == 27'h0000000);
   assign a_off     = {haddr[4:2], 2'b00};
   assign hreadyout = ~s_q.wr_pend;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;
   assign alarm_event = s_q.evt;
   assign wd        = hwdata[15:0];

   // lanes touched by the access
   always_comb begin
      lane_hi = 1'b1;
      lane_lo = 1'b1;
      if (hsize == 3'h0) begin
         lane_hi = (haddr[1:0] == 2'h1);
         lane_lo = (haddr[1:0] == 2'h0);
      end else if (hsize == 3'h1) begin
         lane_hi = ~haddr[1];
         lane_lo = ~haddr[1];
      end
   end

   // timebase tick, one cycle every half second
   assign tick = (s_q.div == 25'(HALF_SEC_CYC - 1));

   // leap year from BCD year digits
   always_comb begin
      if (s_q.year[4]) begin
         leap = (s_q.year[3:0] == 4'h2) | (s_q.year[3:0] == 4'h6);
      end else begin
         leap = (s_q.year[3:0] == 4'h0) | (s_q.year[3:0] == 4'h4)
              | (s_q.year[3:0] == 4'h8);
      end
   end

   assign feb29 = (s_q.al_md[12:8] == 5'h02) & (s_q.al_md[5:0] == 6'h29);

   // digit comparison selected by the interval mask
   always_comb begin
      logic m_s1;
      logic m_s10;
      logic m_m1;
      logic m_m10;
      logic m_hr;
      logic m_wd;
      logic m_dy;
      logic m_mo;
      m_s1  = (s_q.ms[3:0]   == s_q.al_ms[3:0]);
      m_s10 = (s_q.ms[6:4]   == s_q.al_ms[6:4]);
      m_m1  = (s_q.ms[11:8]  == s_q.al_ms[11:8]);
      m_m10 = (s_q.ms[14:12] == s_q.al_ms[14:12]);
      m_hr  = (s_q.wh[5:0]   == s_q.al_wh[5:0]);
      m_wd  = (s_q.wh[10:8]  == s_q.al_wh[10:8]);
      m_dy  = (s_q.md[5:0]   == s_q.al_md[5:0]);
      m_mo  = (s_q.md[12:8]  == s_q.al_md[12:8]);
      case (s_q.mask)
         `RTCAL_AM_HALF:  match = 1'b1;
         `RTCAL_AM_SEC:   match = ~s_q.half;
         `RTCAL_AM_10S:   match = ~s_q.half & m_s1;
         `RTCAL_AM_MIN:   match = ~s_q.half & m_s1 & m_s10;
         `RTCAL_AM_10M:   match = ~s_q.half & m_s1 & m_s10 & m_m1;
         `RTCAL_AM_HOUR:  match = ~s_q.half & m_s1 & m_s10 & m_m1 & m_m10;
         `RTCAL_AM_DAY:   match = ~s_q.half & m_s1 & m_s10 & m_m1 & m_m10
                                & m_hr;
         `RTCAL_AM_WEEK:  match = ~s_q.half & m_s1 & m_s10 & m_m1 & m_m10
                                & m_hr & m_wd;
         `RTCAL_AM_MONTH: match = ~s_q.half & m_s1 & m_s10 & m_m1 & m_m10
                                & m_hr & m_dy;
         `RTCAL_AM_YEAR:  match = ~s_q.half & m_s1 & m_s10 & m_m1 & m_m10
                                & m_hr & m_dy & m_mo
                                & (~feb29 | leap);
         default:         match = 1'b0;
      endcase
   end

   assign ev_now = tick & s_q.en & match;

   // alarm window read mux
   always_comb begin
      case (s_q.ptr)
         `RTCAL_PTR_MS: win_rd = s_q.al_ms;
         `RTCAL_PTR_WH: win_rd = s_q.al_wh;
         `RTCAL_PTR_MD: win_rd = s_q.al_md;
         default:       win_rd = 16'h0000;
      endcase
   end

   assign cfg_rd = {s_q.en, s_q.fore, s_q.mask, s_q.ptr, s_q.rpt};

   // next state
   always_comb begin
      s_d     = s_q;
      s_d.evt = 1'b0;

      // divider and half-second phase
      if (tick) begin
         s_d.div  = 25'h0000000;
         s_d.half = ~s_q.half;
      end else begin
         s_d.div = s_q.div + 25'h0000001;
      end

      // address phase: capture write, build read data
      if (acc & hwrite) begin
         s_d.wr_pend = mapped;
         s_d.wr_addr = a_off;
         s_d.wr_hi   = lane_hi;
         s_d.wr_lo   = lane_lo;
      end
      if (acc & ~hwrite) begin
         s_d.rdata = 32'h00000000;
         if (mapped) begin
            case (a_off)
               `RTCAL_OFF_CFG:  s_d.rdata[15:0] = cfg_rd;
               `RTCAL_OFF_WIN:  s_d.rdata[15:0] = win_rd;
               `RTCAL_OFF_CTL:  s_d.rdata[15:0] = {14'h0000, s_q.half,
                                                   s_q.unlock};
               `RTCAL_OFF_YEAR: s_d.rdata[15:0] = s_q.year;
               `RTCAL_OFF_MD:   s_d.rdata[15:0] = s_q.md;
               `RTCAL_OFF_WH:   s_d.rdata[15:0] = s_q.wh;
               `RTCAL_OFF_MS:   s_d.rdata[15:0] = s_q.ms;
               `RTCAL_OFF_ALMD: s_d.rdata[15:0] = s_q.al_md;
               default:         s_d.rdata = 32'h00000000;
            endcase
            // any read of the window steps the pointer down, stopping at zero
            if (a_off == `RTCAL_OFF_WIN && s_q.ptr != 2'h0) begin
               s_d.ptr = s_q.ptr - 2'h1;
            end
         end
      end

      // data phase: commit the write, one wait state
      if (s_q.wr_pend) begin
         s_d.wr_pend = 1'b0;
         case (s_q.wr_addr)
            `RTCAL_OFF_CFG: begin
               if (s_q.wr_hi) begin
                  s_d.en   = hwdata[`RTCAL_CFG_EN];
                  s_d.fore = hwdata[`RTCAL_CFG_FOREVER];
                  s_d.mask = hwdata[`RTCAL_CFG_MASK_HI:`RTCAL_CFG_MASK_LO];
                  s_d.ptr  = hwdata[`RTCAL_CFG_PTR_HI:`RTCAL_CFG_PTR_LO];
               end
               if (s_q.wr_lo) begin
                  s_d.rpt = hwdata[7:0];
               end
            end
            `RTCAL_OFF_WIN: begin
               case (s_q.ptr)
                  `RTCAL_PTR_MS: s_d.al_ms = wr16(s_q.al_ms, wd, s_q.wr_hi,
                                                 s_q.wr_lo, `RTCAL_MS_BITS);
                  `RTCAL_PTR_WH: if (s_q.unlock) begin
                     s_d.al_wh = wr16(s_q.al_wh, wd, s_q.wr_hi,
                                      s_q.wr_lo, `RTCAL_WH_BITS);
                  end
                  `RTCAL_PTR_MD: if (s_q.unlock) begin
                     s_d.al_md = wr16(s_q.al_md, wd, s_q.wr_hi,
                                      s_q.wr_lo, `RTCAL_MD_BITS);
                  end
                  default: ;
               endcase
               if (s_q.wr_hi && s_q.ptr != 2'h0) begin
                  s_d.ptr = s_q.ptr - 2'h1;
               end
            end
            `RTCAL_OFF_CTL: begin
               if (s_q.wr_lo) begin
                  s_d.unlock = hwdata[`RTCAL_CTL_UNLOCK];
               end
            end
            `RTCAL_OFF_YEAR: if (s_q.unlock) begin
               s_d.year = wr16(s_q.year, wd, s_q.wr_hi, s_q.wr_lo,
                               `RTCAL_YEAR_BITS);
            end
            `RTCAL_OFF_MD: if (s_q.unlock) begin
               s_d.md = wr16(s_q.md, wd, s_q.wr_hi, s_q.wr_lo,
                             `RTCAL_MD_BITS);
            end
            `RTCAL_OFF_WH: if (s_q.unlock) begin
               s_d.wh = wr16(s_q.wh, wd, s_q.wr_hi, s_q.wr_lo,
                             `RTCAL_WH_BITS);
            end
            `RTCAL_OFF_MS: if (s_q.unlock) begin
               s_d.ms = wr16(s_q.ms, wd, s_q.wr_hi, s_q.wr_lo,
                             `RTCAL_MS_BITS);
            end
            `RTCAL_OFF_ALMD: if (s_q.unlock) begin
               s_d.al_md = wr16(s_q.al_md, wd, s_q.wr_hi, s_q.wr_lo,
                                `RTCAL_MD_BITS);
            end
            default: ;
         endcase
      end

      // alarm event wins over a software write in the same cycle
      if (ev_now) begin
         s_d.evt = 1'b1;
         if (s_q.rpt != `RTCAL_RPT_ZERO) begin
            s_d.rpt = s_q.rpt - 8'h01;
            s_d.en  = 1'b1;
         end else if (s_q.fore) begin
            s_d.rpt = `RTCAL_RPT_FULL;
            s_d.en  = 1'b1;
         end else begin
            s_d.rpt = `RTCAL_RPT_ZERO;
            s_d.en  = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q      <= '0;
         s_q.mask <= 4'(`RTCAL_CFG_RST >> `RTCAL_CFG_MASK_LO);
      end else begin
         s_q <= s_d;
      end
   end

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic rd_win;
   logic rd_year;
   logic rd_ms;
   assign rd_win  = acc & ~hwrite & mapped & (a_off == `RTCAL_OFF_WIN);
   assign rd_year = acc & ~hwrite & mapped & (a_off == `RTCAL_OFF_YEAR);
   assign rd_ms   = acc & ~hwrite & mapped & (a_off == `RTCAL_OFF_MS);

   a_auto_disable: assert property (
      ev_now && s_q.rpt == 8'h00 && !s_q.fore |=> (!s_q.en)[*2])
      else $error("alarm stayed enabled after last event");

   a_count_wrap: assert property (
      ev_now && s_q.fore && s_q.rpt == 8'h00 |=> s_q.rpt == 8'hFF && s_q.en)
      else $error("repeat count did not wrap");

   a_count_hold: assert property (
      !s_q.fore && s_q.rpt == 8'h00 && !s_q.wr_pend |=> s_q.rpt == 8'h00)
      else $error("repeat count left zero");

   a_count_step: assert property (
      ev_now && s_q.rpt != 8'h00 |=> s_q.rpt == $past(s_q.rpt) - 8'h01)
      else $error("repeat count not decremented");

   a_ptr_write: assert property (
      s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_WIN && s_q.wr_hi
      && s_q.ptr != 2'h0 |=> s_q.ptr == $past(s_q.ptr) - 2'h1)
      else $error("pointer not stepped on high write");

   a_ptr_read: assert property (
      rd_win && s_q.ptr != 2'h0 |=> s_q.ptr == $past(s_q.ptr) - 2'h1)
      else $error("pointer not stepped on read");

   a_ptr_floor: assert property (
      s_q.ptr == 2'h0 && !(s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_CFG)
      |=> s_q.ptr == 2'h0)
      else $error("pointer went below zero");

   a_year_lock: assert property (
      s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_YEAR && !s_q.unlock
      |=> $stable(s_q.year))
      else $error("locked year register changed");

   a_almd_lock: assert property (
      s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_ALMD && !s_q.unlock
      |=> $stable(s_q.al_md))
      else $error("locked alarm date changed");

   a_value_lock: assert property (
      s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_MS && !s_q.unlock |=> $stable(s_q.ms))
      else $error("locked minute/second register changed");

   a_alarm_req: assert property (
      ev_now |=> alarm_event ##1 !alarm_event)
      else $error("alarm request not a single pulse");

   a_year_upper: assert property (
      rd_year |=> hrdata[15:8] == 8'h00 && hrdata[7:0] == $past(s_q.year[7:0]))
      else $error("year upper byte not zero");

   a_ms_gaps: assert property (
      rd_ms |=> !hrdata[15] && !hrdata[7])
      else $error("minute/second reserved bits set");

   a_leap_only: assert property (
      ev_now && s_q.mask == `RTCAL_AM_YEAR && feb29 |-> leap)
      else $error("Feb 29 alarm outside leap year");

   c_single: cover property (ev_now && !s_q.fore && s_q.rpt == 8'h00);
   c_wrap: cover property (ev_now && s_q.fore && s_q.rpt == 8'h00);
   c_walk: cover property (rd_win ##1 rd_win ##1 rd_win);
   c_leap: cover property (ev_now && s_q.mask == `RTCAL_AM_YEAR && feb29);
   c_locked: cover property (s_q.wr_pend && s_q.wr_addr == `RTCAL_OFF_YEAR && !s_q.unlock);

endmodule : rtcal_top
`default_nettype wire

// *** logic/rtcal_defs.svh ***
// offsets, field positions, reset values and timing counts of the alarm block
// assumes: included by bare name from the top module and the bench
`ifndef RTCAL_DEFS_SVH
`define RTCAL_DEFS_SVH

// byte offsets, one aligned word each
`define RTCAL_OFF_CFG     5'h00
`define RTCAL_OFF_WIN     5'h04
`define RTCAL_OFF_CTL     5'h08
`define RTCAL_OFF_YEAR    5'h0C
`define RTCAL_OFF_MD      5'h10
`define RTCAL_OFF_WH      5'h14
`define RTCAL_OFF_MS      5'h18
`define RTCAL_OFF_ALMD    5'h1C

// alarm_config fields
`define RTCAL_CFG_EN      15
`define RTCAL_CFG_FOREVER 14
`define RTCAL_CFG_MASK_HI 13
`define RTCAL_CFG_MASK_LO 10
`define RTCAL_CFG_PTR_HI  9
`define RTCAL_CFG_PTR_LO  8
`define RTCAL_CFG_RST     16'h0000

// control fields
`define RTCAL_CTL_UNLOCK  0
`define RTCAL_CTL_HALF    1

// implemented bits of the value layouts
`define RTCAL_YEAR_BITS   16'h00FF
`define RTCAL_MD_BITS     16'h1F3F
`define RTCAL_WH_BITS     16'h073F
`define RTCAL_MS_BITS     16'h7F7F

// window pointer values
`define RTCAL_PTR_MS      2'h0
`define RTCAL_PTR_WH      2'h1
`define RTCAL_PTR_MD      2'h2

// repeat counter limits
`define RTCAL_RPT_ZERO    8'h00
`define RTCAL_RPT_FULL    8'hFF

// interval mask codes
`define RTCAL_AM_HALF     4'h0
`define RTCAL_AM_SEC      4'h1
`define RTCAL_AM_10S      4'h2
`define RTCAL_AM_MIN      4'h3
`define RTCAL_AM_10M      4'h4
`define RTCAL_AM_HOUR     4'h5
`define RTCAL_AM_DAY      4'h6
`define RTCAL_AM_WEEK     4'h7
`define RTCAL_AM_MONTH    4'h8
`define RTCAL_AM_YEAR     4'h9

// timebase
`define RTCAL_CLK_NS      20
`define RTCAL_HALF_SEC_NS 500000000

`endif

// *** logic/rtcal_pkg.sv ***
// types of the alarm configuration block
// assumes: nothing beyond the defines header
`default_nettype none
package rtcal_pkg;
   typedef struct packed {
      logic        en;
      logic        fore;
      logic [3:0]  mask;
      logic [1:0]  ptr;
      logic [7:0]  rpt;
      logic        unlock;
      logic [15:0] year;
      logic [15:0] md;
      logic [15:0] wh;
      logic [15:0] ms;
      logic [15:0] al_md;
      logic [15:0] al_wh;
      logic [15:0] al_ms;
      logic [24:0] div;
      logic        half;
      logic        wr_pend;
      logic [4:0]  wr_addr;
      logic        wr_hi;
      logic        wr_lo;
      logic [31:0] rdata;
      logic        evt;
   } rtcal_state_t;
endpackage : rtcal_pkg
`default_nettype wire

// *** verif/rtcal_tb.sv ***
// self-checking bench for the alarm configuration and value register block
// assumes: rtcal_top alone on an ahb-lite bus driven by this bench, short timebase
`timescale 1ns/1ps
`default_nettype none
`include "rtcal_defs.svh"

module testbench;
   // bus and clock
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  logic  hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        alarm_event;
   // bench state
   int          mismatches;
   int          checked;
   logic [31:0] ev_cnt;
   logic [31:0] scratch;
   logic [31:0] offs [5];
   logic [31:0] bits [5];

   localparam int TICK = 8;
   localparam logic [31:0] A_CFG = {27'h0000000, `RTCAL_OFF_CFG};
   localparam logic [31:0] A_WIN = {27'h0000000, `RTCAL_OFF_WIN};
   localparam logic [31:0] A_CTL = {27'h0000000, `RTCAL_OFF_CTL};

   assign hready = hreadyout;

   rtcal_top #(.HALF_SEC_CYC(TICK)) dut (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hsize       (hsize),
      .hwdata      (hwdata),
      .hready      (hready),
      .hrdata      (hrdata),
      .hreadyout   (hreadyout),
      .hresp       (hresp),
      .alarm_event (alarm_event)
   );

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      if (!hresetn) ev_cnt <= 32'h00000000;
      else if (alarm_event === 1'b1) ev_cnt <= ev_cnt + 32'h00000001;
   end

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // waits through one phase until hready is seen high at a rising edge
   task automatic wait_rdy(output logic [31:0] d);
      int   n;
      logic ok;
      n = 0;
      ok = 1'b0;
      d = 32'h00000000;
      while (!ok) begin
         @(negedge hclk);
         ok = (hreadyout === 1'b1);
         d = hrdata;
         @(posedge hclk);
         n++;
         if (n > 20) begin
            mismatches++;
            wrap_up();
         end
      end
   endtask : wait_rdy

   // one single transfer, entered and left just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd);
      logic [31:0] dummy;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= sz;
      wait_rdy(dummy);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy(rd);
   endtask : ahb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, 3'h2, d, scratch);
   endtask : wr

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      ahb(1'b0, a, 3'h2, 32'h00000000, v);
      check(v, exp);
   endtask : rd_chk

   task automatic count_ev(input int n, input logic [31:0] exp);
      logic [31:0] base;
      // skip the edge whose pulse still reflects the old settings
      @(posedge hclk);
      base = ev_cnt;
      repeat (n) @(posedge hclk);
      check(ev_cnt - base, exp);
   endtask : count_ev

   // aligns to just after a pulse so the next tick is far away
   task automatic wait_ev();
      int n;
      n = 0;
      while (1) begin
         @(negedge hclk);
         if (alarm_event === 1'b1) break;
         n++;
         if (n > 100) begin
            mismatches++;
            wrap_up();
         end
      end
      @(posedge hclk);
   endtask : wait_ev

   initial begin
      mismatches = 0;
      checked = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      offs = '{{27'h0, `RTCAL_OFF_YEAR}, {27'h0, `RTCAL_OFF_MD}, {27'h0, `RTCAL_OFF_WH},
               {27'h0, `RTCAL_OFF_MS}, {27'h0, `RTCAL_OFF_ALMD}};
      bits = '{32'h000000FF, 32'h00001F3F, 32'h0000073F, 32'h00007F7F, 32'h00001F3F};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(A_CFG, 32'h00000000);
      // value registers locked, then open with unused bits reading zero
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], 32'h0000FFFF);
         rd_chk(offs[i], 32'h00000000);
      end
      wr(A_CTL, 32'h00000001);
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], 32'h0000FFFF);
         rd_chk(offs[i], bits[i]);
         wr(offs[i], 32'h00000000);
      end
      // repeat count of two gives three events, then disable
      wr(A_CFG, 32'h00008402);
      count_ev(10 * TICK, 32'h00000003);
      rd_chk(A_CFG, 32'h00000400);
      // forever mode wraps the count
      wr(A_CFG, 32'h0000C400);
      wait_ev();
      rd_chk(A_CFG, 32'h0000C4FF);
      // every defined mask code; reserved codes are never programmed
      for (int m = 0; m < 10; m++) begin
         wr(A_CFG, 32'h0000C000 | (m << 10));
         count_ev(4 * TICK, (m == 0) ? 32'h4 : 32'h2);
         wait_ev();
      end
      // a differing seconds digit stops the ten-second mask, not the half-second one
      wr(A_CFG, 32'h00000000);
      wr(A_WIN, 32'h00000001);
      wr(A_CFG, 32'h0000C800);
      count_ev(4 * TICK, 32'h00000000);
      wr(A_CFG, 32'h0000C000);
      count_ev(4 * TICK, 32'h00000004);
      wait_ev();
      wr(A_CFG, 32'h00000000);
      wr(A_WIN, 32'h00000000);
      // yearly alarm on the leap day
      wr({27'h0, `RTCAL_OFF_MD}, 32'h00000229);
      wr({27'h0, `RTCAL_OFF_YEAR}, 32'h00000001);
      wr(A_CFG, 32'h00000200);
      wr(A_WIN, 32'h00000229);
      wr(A_CFG, 32'h0000E400);
      count_ev(4 * TICK, 32'h00000000);
      wr({27'h0, `RTCAL_OFF_YEAR}, 32'h00000004);
      count_ev(4 * TICK, 32'h00000002);
      wait_ev();
      wr(A_CFG, 32'h00000000);
      // window pointer walk
      wr(A_CFG, 32'h00000200);
      wr(A_WIN, 32'h00001225);
      wr(A_WIN, 32'h00000312);
      wr(A_WIN, 32'h00004530);
      wr(A_CFG, 32'h00000200);
      rd_chk(A_WIN, 32'h00001225);
      rd_chk(A_CFG, 32'h00000100);
      rd_chk(A_WIN, 32'h00000312);
      rd_chk(A_CFG, 32'h00000000);
      rd_chk(A_WIN, 32'h00004530);
      rd_chk(A_CFG, 32'h00000000);
      wr(A_CFG, 32'h00000100);
      ahb(1'b1, A_WIN, 3'h0, 32'h00000011, scratch);
      rd_chk(A_CFG, 32'h00000100);
      rd_chk(A_WIN, 32'h00000311);
      wr(A_CFG, 32'h00000300);
      rd_chk(A_WIN, 32'h00000000);
      rd_chk(A_CFG, 32'h00000200);
      // locked window write to the alarm date is dropped
      wr(A_CTL, 32'h00000000);
      wr(A_CFG, 32'h00000200);
      wr(A_WIN, 32'h00000101);
      wr(A_CFG, 32'h00000200);
      rd_chk(A_WIN, 32'h00001225);
      // unmapped place
      wr(32'h00000020, 32'h0000FFFF);
      rd_chk(32'h00000020, 32'h00000000);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
